// ==== design/boot_area_and_readout_guard.sv ====
// boot region write protect and read-out guard
`timescale 1ns/10ps
module boot_area_and_readout_guard
    import guard_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // mode and configuration
    input wire logic in_circuit_programming_mode_i,
    input wire logic in_application_programming_i,
    input wire logic main_area_unlock_keys_i,
    input wire logic [UBR_W-1:0] ubr_pages_i,
    input wire logic ubr_load_i,
    input wire logic guard_init_i,
    input wire logic guard_load_i,
    input wire logic guard_set_req_i,
    input wire logic guard_val_i,
    // memory access request
    input wire logic acc_req_i,
    input wire logic acc_wr_i,
    input wire logic acc_ext_i,
    input wire logic [ADDR_W-1:0] acc_addr_i,
    // decisions and status
    output logic acc_grant_o,
    output logic acc_deny_o,
    output logic readout_guard_o,
    output logic erase_busy_o,
    output logic erase_start_o,
    output logic [UBR_W-1:0] user_boot_region_o
);
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_ERASE = 2'b10
    } st_e;

    typedef struct packed {
        st_e st;
        logic guard;
        logic [UBR_W-1:0] pages;
        logic [4:0] cnt;
        logic grant;
        logic deny;
        logic start;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic in_flash;
    logic in_eeprom;
    logic in_boot;
    logic allow;
    // deny causes, kept apart so each rule reads on its own
    logic deny_busy;
    logic deny_guard;
    logic deny_boot;
    logic deny_main;

    region_decode u_dec (
        .addr_i(acc_addr_i),
        .pages_i(s_r.pages),
        .in_flash_o(in_flash),
        .in_eeprom_o(in_eeprom),
        .in_boot_o(in_boot)
    );

    always_comb begin
        // nothing passes while memory is being wiped
        deny_busy = (s_r.st != ST_RUN);
        deny_guard = acc_ext_i && s_r.guard && (in_flash || in_eeprom);
        // keys are not looked at here: they never open the boot region
        deny_boot = acc_wr_i && in_boot && in_application_programming_i;
        deny_main = acc_wr_i && in_flash && !in_boot && !main_area_unlock_keys_i
                    && !in_circuit_programming_mode_i;
        allow = !(deny_busy || deny_guard || deny_boot || deny_main);
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.grant = acc_req_i && allow;
        s_nxt.deny = acc_req_i && !allow;
        s_nxt.start = 1'b0;
        case (s_r.st)
            ST_RUN: begin
                // boot size only accepted from the programmer side
                if (ubr_load_i && in_circuit_programming_mode_i) begin
                    s_nxt.pages = ubr_pages_i;
                end
                if (guard_set_req_i && s_r.guard && !guard_load_i) begin
                    // any toggle attempt on an active guard wipes memory
                    s_nxt.st = ST_ERASE;
                    s_nxt.start = 1'b1;
                    s_nxt.cnt = 5'(ERASE_CYCLES - 1);
                    s_nxt.guard = guard_val_i;
                end else if (guard_set_req_i && !guard_load_i) begin
                    s_nxt.guard = guard_val_i;
                end
            end
            ST_ERASE: begin
                if (s_r.cnt == 5'h00) begin
                    s_nxt.st = ST_RUN;
                end else begin
                    s_nxt.cnt = s_r.cnt - 5'h01;
                end
            end
            default: s_nxt.st = ST_RUN;
        endcase
        // stored option captured after reset wins over a same-cycle request
        if (guard_load_i) begin
            s_nxt.guard = guard_init_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_r.st <= ST_RUN;
            s_r.guard <= 1'b0;
            s_r.pages <= UBR_RST;
            s_r.cnt <= 5'h00;
            s_r.grant <= 1'b0;
            s_r.deny <= 1'b0;
            s_r.start <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign acc_grant_o = s_r.grant;
    assign acc_deny_o = s_r.deny;
    assign readout_guard_o = s_r.guard;
    assign erase_busy_o = (s_r.st == ST_ERASE);
    assign erase_start_o = s_r.start;
    assign user_boot_region_o = s_r.pages;

    // access decisions
    a_boot_wr_block: assert property (@(posedge mclk_i) disable iff (srst_i)
        acc_req_i && acc_wr_i && in_boot && in_application_programming_i
        |=> acc_deny_o && !acc_grant_o)
        else $error("boot write granted during application programming");

    a_keys_no_boot: assert property (@(posedge mclk_i) disable iff (srst_i)
        acc_req_i && acc_wr_i && in_boot && main_area_unlock_keys_i && in_application_programming_i
        |=> !acc_grant_o)
        else $error("unlock keys opened boot region");

    a_main_open: assert property (@(posedge mclk_i) disable iff (srst_i)
        acc_req_i && acc_wr_i && in_flash && !in_boot && main_area_unlock_keys_i
        && !acc_ext_i && !erase_busy_o |=> acc_grant_o)
        else $error("unlock keys did not open main area");

    a_guard_blocks: assert property (@(posedge mclk_i) disable iff (srst_i)
        acc_req_i && acc_ext_i && readout_guard_o && (in_flash || in_eeprom)
        |=> acc_deny_o)
        else $error("external access passed guard");

    a_one_answer: assert property (@(posedge mclk_i) disable iff (srst_i)
        acc_req_i |=> acc_grant_o != acc_deny_o)
        else $error("request without exactly one answer");

    a_idle_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
        !acc_req_i |=> !acc_grant_o && !acc_deny_o)
        else $error("answer without request");

    a_grant_excl: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(acc_grant_o && acc_deny_o))
        else $error("grant and deny together");

    // erase sequence
    a_erase_denies: assert property (@(posedge mclk_i) disable iff (srst_i)
        erase_busy_o && acc_req_i |=> acc_deny_o)
        else $error("access granted during erase");

    a_toggle_erase: assert property (@(posedge mclk_i) disable iff (srst_i)
        guard_set_req_i && readout_guard_o && !erase_busy_o && !guard_load_i
        |=> erase_start_o ##1 erase_busy_o[*8])
        else $error("guard change without erase");

    a_start_busy: assert property (@(posedge mclk_i) disable iff (srst_i)
        erase_start_o |-> erase_busy_o)
        else $error("erase start without busy");

    a_start_pulse: assert property (@(posedge mclk_i) disable iff (srst_i)
        erase_start_o |=> !erase_start_o)
        else $error("erase start longer than one cycle");

    // a cut erase after reset is not a short erase
    a_erase_len: assert property (@(posedge mclk_i) disable iff (srst_i)
        $fell(erase_busy_o) && !$past(srst_i) |-> $past(erase_start_o, ERASE_CYCLES))
        else $error("erase length wrong");

    a_busy_hold_guard: assert property (@(posedge mclk_i) disable iff (srst_i)
        erase_busy_o && !guard_load_i |=> $stable(readout_guard_o))
        else $error("guard changed during erase");

    a_no_erase_idle: assert property (@(posedge mclk_i) disable iff (srst_i)
        guard_set_req_i && !readout_guard_o && !erase_busy_o && !guard_load_i
        |=> !erase_start_o && (readout_guard_o == $past(guard_val_i)))
        else $error("inactive guard not set plainly");

    a_guard_strap: assert property (@(posedge mclk_i) disable iff (srst_i)
        guard_load_i |=> readout_guard_o == $past(guard_init_i))
        else $error("stored guard not captured");

    // reset must clear everything, so no disable here
    a_reset_state: assert property (@(posedge mclk_i)
        srst_i |=> !acc_grant_o && !acc_deny_o && !erase_start_o && !erase_busy_o
        && !readout_guard_o && (user_boot_region_o == UBR_RST))
        else $error("state not cleared by reset");

    // decode and boot size
    a_boot_limit: assert property (@(posedge mclk_i) disable iff (srst_i)
        in_boot |-> (((acc_addr_i - FLASH_BASE) >> PAGE_SHIFT) < ADDR_W'(s_r.pages)))
        else $error("boot decode beyond pages");

    a_boot_pages: assert property (@(posedge mclk_i) disable iff (srst_i)
        (s_r.pages != 8'h00) && (acc_addr_i == FLASH_BASE) |-> in_boot)
        else $error("boot region not at flash start");

    a_flash_span: assert property (@(posedge mclk_i) disable iff (srst_i)
        in_flash |-> (acc_addr_i >= FLASH_BASE) && (acc_addr_i < FLASH_BASE + ADDR_W'(FLASH_BYTES)))
        else $error("flash decode past 128K");

    a_pages_icp: assert property (@(posedge mclk_i) disable iff (srst_i)
        !in_circuit_programming_mode_i |=> $stable(user_boot_region_o))
        else $error("boot size changed outside programming mode");

    a_size_load: assert property (@(posedge mclk_i) disable iff (srst_i)
        ubr_load_i && in_circuit_programming_mode_i && !erase_busy_o
        |=> user_boot_region_o == $past(ubr_pages_i))
        else $error("boot size not loaded in programming mode");
endmodule : boot_area_and_readout_guard

// ==== design/guard_pkg.sv ====
// constants for the boot area and read-out guard
package guard_pkg;
    localparam int PAGE_BYTES = 512;
    localparam int PAGE_SHIFT = 9;
    localparam int FLASH_BYTES = 131072;
    localparam int ADDR_W = 24;
    localparam int OFF_W = 17;
    localparam int UBR_W = 8;
    localparam logic [23:0] FLASH_BASE = 24'h008000;
    localparam logic [23:0] EEPROM_BASE = 24'h004000;
    localparam int EEPROM_BYTES = 2048;
    localparam int ERASE_CYCLES = 16;
    localparam logic [7:0] UBR_RST = 8'h00;
endpackage : guard_pkg

// ==== design/region_decode.sv ====
// address decoder for flash, eeprom and boot region
`timescale 1ns/10ps
module region_decode
    import guard_pkg::*;
(
    // address and boot size
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [UBR_W-1:0] pages_i,
    // decode results
    output logic in_flash_o,
    output logic in_eeprom_o,
    output logic in_boot_o
);
    logic [ADDR_W-1:0] off;
    logic [ADDR_W-1:0] eoff;
    logic [ADDR_W-1:0] limit;
    always_comb begin
        off = addr_i - FLASH_BASE;
        eoff = addr_i - EEPROM_BASE;
        limit = ADDR_W'(pages_i) << PAGE_SHIFT;
        in_flash_o = (addr_i >= FLASH_BASE) && (off < ADDR_W'(FLASH_BYTES));
        in_eeprom_o = (addr_i >= EEPROM_BASE) && (eoff < ADDR_W'(EEPROM_BYTES));
        in_boot_o = in_flash_o && (off < limit);
    end
endmodule : region_decode

// ==== tb/boot_area_and_readout_guard_tb.sv ====
// testbench for boot area and read-out guard
`timescale 1ns/10ps
module boot_area_and_readout_guard_tb;
    import guard_pkg::*;
    logic mclk_i = 0, srst_i = 1, in_application_programming = 0, keys = 0, gl = 0, gs = 0, gv = 0, g = 0, ers = 0;
    logic req = 0, wr = 0, ext = 0, go = 0, in_circuit_programming_mode, ld, gr, dn, gd, bz, st;
    logic gi = 0;
    localparam int CYC_LIMIT = 400;
    logic [ADDR_W-1:0] ad = '0;
    logic [UBR_W-1:0] pg, ub, sz = 8'h02;
    logic q[$];
    int n_mismatch = 0, check_count = 0, cyc = 0, nb = 0, ns = 0, k;
    int seed = 32'h5c25;
    always #12.5 mclk_i = ~mclk_i;
    prog_tool_model prog_tool_model_inst (.mclk_i(mclk_i), .go_i(go), .size_i(sz),
        .icp_o(in_circuit_programming_mode), .pages_o(pg), .load_o(ld));
    boot_area_and_readout_guard boot_area_and_readout_guard_inst (.mclk_i(mclk_i),
        .srst_i(srst_i), .in_circuit_programming_mode_i(in_circuit_programming_mode), .in_application_programming_i(in_application_programming),
        .main_area_unlock_keys_i(keys), .ubr_pages_i(pg), .ubr_load_i(ld), .guard_init_i(gi),
        .guard_load_i(gl), .guard_set_req_i(gs), .guard_val_i(gv), .acc_req_i(req),
        .acc_wr_i(wr), .acc_ext_i(ext), .acc_addr_i(ad), .acc_grant_o(gr), .acc_deny_o(dn),
        .readout_guard_o(gd), .erase_busy_o(bz), .erase_start_o(st), .user_boot_region_o(ub));
    task tally(input logic ok, input string what);
        check_count++;
        if (!ok) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : tally
    task cmp_dec(input logic [1:0] got, input logic [1:0] exp);
        tally(got === exp, "access decision");
    endtask : cmp_dec
    task cmp_size(input logic [UBR_W-1:0] got, input logic [UBR_W-1:0] exp);
        tally(got === exp, "boot page count");
    endtask : cmp_size
    task cmp_stat(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, "guard or erase status");
    endtask : cmp_stat
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // called at a falling edge; back to back calls keep the request up
    task acc(input logic w, input logic x, input logic [ADDR_W-1:0] a);
        logic fl, ee, bt;
        fl = a >= FLASH_BASE && a < FLASH_BASE + FLASH_BYTES;
        ee = a >= EEPROM_BASE && a < EEPROM_BASE + EEPROM_BYTES;
        bt = fl && (a - FLASH_BASE) < sz * PAGE_BYTES;
        // expected deny from the rules and the bench's own view of guard and erase
        q.push_back(ers || (x && g && (fl || ee))
                    || (w && fl && ((bt && in_application_programming) || (!bt && !keys && !in_circuit_programming_mode))));
        req = 1;
        wr = w;
        ext = x;
        ad = a;
        @(negedge mclk_i);
    endtask : acc
    always @(posedge mclk_i) begin
        #1;
        cyc++;
        if (bz === 1'b1) nb++;
        if (st === 1'b1) ns++;
        if ((gr | dn) === 1'b1) begin
            if (q.size() == 0) begin
                tally(1'b0, "answer without request");
            end else begin
                cmp_dec({gr, dn}, {!q[0], q[0]});
                q.pop_front();
            end
        end
    end
    task run_tests;
        repeat (4) @(negedge mclk_i);
        srst_i = 0;
        gl = 1;
        cmp_size(ub, UBR_RST);
        @(negedge mclk_i);
        gl = 0;
        go = 1;
        @(negedge mclk_i);
        go = 0;
        repeat (4) @(negedge mclk_i);
        cmp_size(ub, sz);
        $display("test boot size done");
        in_application_programming = 1;
        acc(1, 0, FLASH_BASE + 24'h3ff);
        acc(1, 0, FLASH_BASE + 24'h400);
        keys = 1;
        acc(1, 0, FLASH_BASE + 24'h3ff);
        acc(1, 0, FLASH_BASE + 24'h400);
        for (k = 0; k < 40; k++) acc(1, 0, FLASH_BASE + ($random(seed) & 24'h1ffff));
        req = 0;
        gv = 1;
        gs = 1;
        @(negedge mclk_i);
        gs = 0;
        g = 1;
        repeat (3) @(negedge mclk_i);
        cmp_stat({gd, bz, 6'h00}, 8'h80);
        $display("test boot write protect done");
        acc(0, 1, FLASH_BASE);
        acc(0, 1, EEPROM_BASE);
        acc(0, 0, FLASH_BASE + 24'h10);
        req = 0;
        gv = 0;
        gs = 1;
        @(negedge mclk_i);
        gs = 0;
        ers = 1;
        g = 0;
        @(negedge mclk_i);
        acc(0, 0, FLASH_BASE);
        req = 0;
        ers = 0;
        repeat (24) @(negedge mclk_i);
        cmp_stat(8'(nb), 8'(ERASE_CYCLES));
        cmp_stat({ns[6:0], gd}, 8'h02);
        $display("test read-out guard done");
        // one cycle of reset in mid-run, then the stored guard comes back set
        srst_i = 1;
        @(negedge mclk_i);
        srst_i = 0;
        gi = 1;
        gl = 1;
        cmp_size(ub, UBR_RST);
        cmp_stat({gd, bz, 6'h00}, 8'h00);
        @(negedge mclk_i);
        gl = 0;
        g = 1;
        cmp_stat({gd, bz, 6'h00}, 8'h80);
        acc(0, 1, EEPROM_BASE + 24'h7ff);
        req = 0;
        repeat (2) @(negedge mclk_i);
        tally(q.size() == 0, "request left unanswered");
        $display("test reset and stored guard done");
    endtask : run_tests
    initial begin
        fork
            run_tests;
            begin
                wait (cyc >= CYC_LIMIT);
                tally(1'b0, "cycle limit reached");
            end
        join_any
        complete_run;
    end
endmodule : boot_area_and_readout_guard_tb

// ==== tb/prog_tool_model.sv ====
// programming tool model that loads the boot size
`timescale 1ns/10ps
module prog_tool_model
    import guard_pkg::*;
(
    // clock and command
    input wire logic mclk_i,
    input wire logic go_i,
    input wire logic [UBR_W-1:0] size_i,
    // tool side of the block
    output logic icp_o = 1'b0,
    output logic [UBR_W-1:0] pages_o = 8'h00,
    output logic load_o = 1'b0
);
    logic [1:0] step = 2'h0;
    always @(posedge mclk_i) begin
        step <= go_i ? 2'h1 : (step == 2'h0 ? 2'h0 : step + 2'h1);
        icp_o <= go_i || step == 2'h1;
        // load only while programming mode is already up
        load_o <= step == 2'h1;
        // size is not held once the load is over
        pages_o <= step == 2'h1 ? size_i : ~pages_o;
    end
endmodule : prog_tool_model
